/* verilog/i2c_slv_pkg.sv */
package i2c_slv_pkg;
  // register bus widths
  localparam int          ADDR_W = 32;
  localparam int          DATA_W = 16;

  // register byte addresses
  localparam logic [31:0] CTRL_OFS   = 32'h4000_3428;
  localparam logic [31:0] STATUS_OFS = 32'h4000_342c;
  localparam logic [31:0] RXDATA_OFS = 32'h4000_3430;
  localparam logic [31:0] TXDATA_OFS = 32'h4000_3434;
  localparam logic [31:0] ALT_OFS    = 32'h4000_3438;
  localparam logic [31:0] ID0_OFS    = 32'h4000_343c;
  localparam logic [31:0] IRQST_OFS  = 32'h4000_3450;
  localparam logic [31:0] IRQMSK_OFS = 32'h4000_3454;

  // control register fields
  localparam int          CT_SLAVE_ON = 0;
  localparam int          CT_GC_EN    = 1;
  localparam int          CT_HWGC_EN  = 2;
  localparam int          CT_GC_CLEAR = 3;
  localparam int          CT_EARLY_TX = 4;
  localparam int          CT_FORCE_NK = 5;
  localparam logic [5:0]  CTRL_RESET  = 6'h00;

  // status register fields
  localparam int          ST_TX_EMPTY = 0;
  localparam int          ST_TX_UNDER = 1;
  localparam int          ST_TX_REQ   = 2;
  localparam int          ST_RX_REQ   = 3;
  localparam int          ST_RX_OVF   = 4;
  localparam int          ST_NACK     = 5;
  localparam int          ST_BUSY     = 6;
  localparam int          ST_GC       = 7;
  localparam int          ST_GCID_LO  = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0001;

  // interrupt event bits, same layout for status and mask
  localparam int          EV_RX_BYTE = 0;
  localparam int          EV_TX_REQ  = 1;
  localparam int          EV_RX_OVF  = 2;
  localparam int          EV_TX_UND  = 3;
  localparam int          EV_NACK    = 4;
  localparam int          EV_W       = 5;
  localparam logic [4:0]  EV_RESET   = 5'h00;

  // general call second bytes and id codes
  localparam logic [7:0]  GC_RESET_BYTE = 8'h06;
  localparam logic [7:0]  GC_PROG_BYTE  = 8'h04;
  localparam logic [7:0]  GC_ADDR       = 8'h00;
  localparam logic [1:0]  GCID_NONE     = 2'h0;
  localparam logic [1:0]  GCID_RESET    = 2'h1;
  localparam logic [1:0]  GCID_PROG     = 2'h2;
  localparam logic [1:0]  GCID_HW       = 2'h3;

  // fifo shape and bit counts
  localparam int          FIFO_DEPTH  = 2;
  localparam logic [1:0]  FIFO_FULL_N = 2'h2;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT = 4'h7;
  localparam logic [7:0]  IDLE_BYTE   = 8'hff;

  // engine states, one-hot
  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_ADDR = 7'b000_0010,
    S_AACK = 7'b000_0100,
    S_RX   = 7'b000_1000,
    S_RACK = 7'b001_0000,
    S_TX   = 7'b010_0000,
    S_TACK = 7'b100_0000
  } eng_state_e;
endpackage

/* verilog/pin_events_if.sv */
`timescale 1ns/1ps
// conditioned bus levels and edges, all on clk
interface pin_events_if;
  logic scl_lvl;    // synchronised scl
  logic sda_lvl;    // synchronised sda
  logic scl_rise;   // one-cycle pulse
  logic scl_fall;   // one-cycle pulse
  logic start_seen; // start or repeated start
  logic stop_seen;  // stop condition
  modport src (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
  modport snk (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  pin_events_if.src  ev
);
  logic [1:0] scl_sync_q; // two-stage synchroniser
  logic [1:0] sda_sync_q;
  logic       scl_prev_q; // previous synced value
  logic       sda_prev_q;

  // bus idles high, so reset to one to avoid false edges
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // edges and bus conditions, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      ev.scl_lvl    <= 1'b1;
      ev.sda_lvl    <= 1'b1;
      ev.scl_rise   <= 1'b0;
      ev.scl_fall   <= 1'b0;
      ev.start_seen <= 1'b0;
      ev.stop_seen  <= 1'b0;
    end else begin
      ev.scl_lvl    <= scl_sync_q[1];
      ev.sda_lvl    <= sda_sync_q[1];
      ev.scl_rise   <= scl_sync_q[1] & ~scl_prev_q;
      ev.scl_fall   <= ~scl_sync_q[1] & scl_prev_q;
      ev.start_seen <= scl_sync_q[1] & scl_prev_q & ~sda_sync_q[1] & sda_prev_q;
      ev.stop_seen  <= scl_sync_q[1] & scl_prev_q & sda_sync_q[1] & ~sda_prev_q;
    end
  end
endmodule

/* verilog/i2c_slave_status_flags.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module i2c_slave_status_flags
  import i2c_slv_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   sda_out,
  output logic                   sda_oe,
  output logic                   irq
);
  pin_events_if ev ();

  // pin conditioning
  pin_sync u_sync (
    .clk    (clk),
    .reset  (reset),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev.src)
  );

  logic [5:0]      ctrl_q;       // control bits
  logic [7:0]      id_q;         // own address in [7:1]
  logic [7:0]      alt_q;        // hardware call match byte
  logic [EV_W-1:0] irq_st_q;     // sticky events
  logic [EV_W-1:0] irq_mask_q;   // event enables
  logic            gc_flag_q;    // general call flag
  logic [1:0]      gcid_q;       // general call kind
  logic            gc_rst_q;     // one-cycle soft reset
  logic            nack_q, ovf_q, txreq_q, under_q, early_q;
  logic            busy_q;       // slave engaged
  eng_state_e      state_q;      // engine state
  logic [3:0]      cnt_q;        // bit counter
  logic [7:0]      sh_q;         // shift register
  logic            rw_q;         // direction of transfer
  logic            gc_phase_q;   // next byte is call byte
  logic            more_q;       // master acked last byte
  logic [7:0]      rx_mem [FIFO_DEPTH];
  logic [7:0]      tx_mem [FIFO_DEPTH];
  logic            rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
  logic [1:0]      rx_cnt_q, tx_cnt_q;

  // decoded accesses and engine events
  logic soft_rst, eng_rst, rd_stat, rd_rx, wr_tx, wr_ctrl;
  logic rx_push, tx_pop, ev_nack, ev_ovf, ev_txreq, ev_under, ev_early;
  logic addr_hit, gc_hit, early_hit, tx_empty, tx_full, rx_full;
  logic [7:0] tx_head;

  assign soft_rst = reset | gc_rst_q;
  assign eng_rst  = soft_rst | ~ctrl_q[CT_SLAVE_ON];
  assign rd_stat  = rd_en & (addr == STATUS_OFS);
  assign rd_rx    = rd_en & (addr == RXDATA_OFS);
  assign wr_tx    = wr_en & (addr == TXDATA_OFS);
  assign wr_ctrl  = wr_en & (addr == CTRL_OFS);
  assign tx_empty = (tx_cnt_q == 2'h0);
  assign tx_full  = (tx_cnt_q == FIFO_FULL_N);
  assign rx_full  = (rx_cnt_q == FIFO_FULL_N);
  assign tx_head  = tx_empty ? IDLE_BYTE : tx_mem[tx_rp_q];
  // address compare once all eight bits are in
  assign addr_hit = (sh_q[7:1] == id_q[7:1]);
  assign gc_hit   = (sh_q == GC_ADDR) & ctrl_q[CT_GC_EN];
  // eighth rise: seven address bits held, direction on sda
  assign early_hit = state_q == S_ADDR && ev.scl_rise && cnt_q == LAST_TX_BIT
                     && ev.sda_lvl && sh_q[6:0] == id_q[7:1];

  // decisions taken at the falling edge that ends the address byte
  logic addr_end, addr_ok, addr_nk;
  assign addr_end = state_q == S_ADDR && ev.scl_fall && cnt_q == BITS_BYTE;
  assign addr_ok  = addr_end & (addr_hit | gc_hit);
  assign addr_nk  = addr_ok & ((sh_q[0] & tx_empty) | ctrl_q[CT_FORCE_NK]);
  assign ev_nack  = addr_nk;
  assign ev_txreq = (addr_ok & ~addr_nk & sh_q[0] & ~ctrl_q[CT_EARLY_TX])
                    | (early_hit & ctrl_q[CT_EARLY_TX]);
  assign ev_early = early_hit & ctrl_q[CT_EARLY_TX];
  // byte lands at last bit fall
  assign rx_push  = state_q == S_RX && ev.scl_fall && cnt_q == BITS_BYTE;
  assign ev_ovf   = rx_push & rx_full;
  assign ev_under = ev.scl_rise & tx_empty
                    & ((state_q == S_AACK & rw_q) | (state_q == S_TACK & ~ev.sda_lvl));
  assign tx_pop   = ev.scl_fall & ((state_q == S_AACK & rw_q) | (state_q == S_TACK & more_q))
                    & ~tx_empty;

  // control and address registers
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      ctrl_q     <= CTRL_RESET;
      id_q       <= 8'h00;
      alt_q      <= 8'h00;
      irq_mask_q <= EV_RESET;
    end else if (wr_en) begin
      // clear bit is a strobe, never stored
      if (wr_ctrl) ctrl_q <= wr_data[5:0] & ~(6'h01 << CT_GC_CLEAR);
      if (addr == ID0_OFS) id_q <= wr_data[7:0];
      if (addr == ALT_OFS) alt_q <= wr_data[7:0];
      if (addr == IRQMSK_OFS) irq_mask_q <= wr_data[EV_W-1:0];
    end
  end

  // general call flag survives call reset, only full reset or clear write
  always_ff @(posedge clk) begin
    if (reset) begin
      gc_flag_q <= 1'b0;
      gcid_q    <= GCID_NONE;
      gc_rst_q  <= 1'b0;
    end else begin
      gc_rst_q <= 1'b0;
      if (rx_push && gc_phase_q) begin
        gc_flag_q <= 1'b1;
        if (sh_q == GC_RESET_BYTE) begin
          gcid_q   <= GCID_RESET;
          gc_rst_q <= 1'b1;
        end else if (sh_q == GC_PROG_BYTE) begin
          gcid_q <= GCID_PROG;
        end else if (ctrl_q[CT_HWGC_EN] && sh_q == alt_q) begin
          gcid_q <= GCID_HW;
        end
      end else if (wr_ctrl && wr_data[CT_GC_CLEAR]) begin
        gc_flag_q <= 1'b0;
        gcid_q    <= GCID_NONE;
      end
    end
  end

  // read-clear flags; a new event beats the clearing read
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      nack_q  <= 1'b0;
      ovf_q   <= 1'b0;
      under_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      nack_q  <= ev_nack | (nack_q & ~rd_stat);
      ovf_q   <= ev_ovf | (ovf_q & ~rd_stat);
      under_q <= ev_under | (under_q & ~rd_stat);
      early_q <= ev_early | (early_q & ~rd_stat);
    end
  end

  // transmit request holds until read or the queue fills
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      txreq_q <= 1'b0;
    end else begin
      txreq_q <= ev_txreq | (txreq_q & ~rd_stat & ~tx_full);
    end
  end

  // receive queue; a push into a full queue is dropped
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      rx_wp_q  <= 1'b0;
      rx_rp_q  <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else begin
      if (rx_push && !rx_full) begin
        rx_mem[rx_wp_q] <= sh_q;
        rx_wp_q         <= ~rx_wp_q;
      end
      if (rd_rx && rx_cnt_q != 2'h0) rx_rp_q <= ~rx_rp_q;
      rx_cnt_q <= rx_cnt_q + 2'((rx_push && !rx_full) ? 1 : 0)
                  - 2'((rd_rx && rx_cnt_q != 2'h0) ? 1 : 0);
    end
  end

  // transmit queue filled by software, drained by the engine
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      tx_wp_q  <= 1'b0;
      tx_rp_q  <= 1'b0;
      tx_cnt_q <= 2'h0;
    end else begin
      if (wr_tx && !tx_full) begin
        tx_mem[tx_wp_q] <= wr_data[7:0];
        tx_wp_q         <= ~tx_wp_q;
      end
      if (tx_pop) tx_rp_q <= ~tx_rp_q;
      tx_cnt_q <= tx_cnt_q + 2'((wr_tx && !tx_full) ? 1 : 0) - 2'(tx_pop ? 1 : 0);
    end
  end

  // busy tracking: start sets; stop, engine reset or an address refused in S_ADDR clears
  always_ff @(posedge clk) begin
    if (eng_rst) begin
      busy_q <= 1'b0;
    end else if (ev.stop_seen) begin
      busy_q <= 1'b0;
    end else if (ev.start_seen) begin
      busy_q <= 1'b1;
    end else if (addr_end && (!addr_ok || addr_nk)) begin
      busy_q <= 1'b0;
    end
  end

  // byte engine: samples on scl rise, drives on scl fall
  always_ff @(posedge clk) begin
    if (eng_rst) begin
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      rw_q       <= 1'b0;
      gc_phase_q <= 1'b0;
      more_q     <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (ev.stop_seen) begin
      state_q <= S_IDLE;
      sda_oe  <= 1'b0;
    end else if (ev.start_seen) begin
      // repeated start re-enters address phase
      state_q    <= S_ADDR;
      cnt_q      <= 4'h0;
      gc_phase_q <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          sda_oe <= 1'b0;
        end
        S_ADDR: begin
          if (ev.scl_rise) begin
            sh_q  <= {sh_q[6:0], ev.sda_lvl};
            cnt_q <= cnt_q + 4'h1;
          end else if (addr_end) begin
            if (addr_ok && !addr_nk) begin
              // ack own address or general call
              sda_oe     <= 1'b1;
              rw_q       <= sh_q[0];
              gc_phase_q <= ~addr_hit;
              state_q    <= S_AACK;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (ev.scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // first data bit out; empty queue sends ones
              sh_q    <= tx_head;
              sda_oe  <= ~tx_head[7];
              state_q <= S_TX;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= S_RX;
            end
          end
        end
        S_RX: begin
          if (ev.scl_rise) begin
            sh_q  <= {sh_q[6:0], ev.sda_lvl};
            cnt_q <= cnt_q + 4'h1;
          end else if (rx_push) begin
            // ack even on overflow; the byte is lost, flag tells software
            sda_oe  <= 1'b1;
            state_q <= S_RACK;
          end
        end
        S_RACK: begin
          if (ev.scl_fall) begin
            gc_phase_q <= 1'b0;
            sda_oe     <= 1'b0;
            cnt_q      <= 4'h0;
            state_q    <= S_RX;
          end
        end
        S_TX: begin
          if (ev.scl_fall) begin
            if (cnt_q == LAST_TX_BIT) begin
              sda_oe  <= 1'b0;
              state_q <= S_TACK;
            end else begin
              sh_q   <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
              cnt_q  <= cnt_q + 4'h1;
            end
          end
        end
        S_TACK: begin
          if (ev.scl_rise) begin
            more_q <= ~ev.sda_lvl;
          end else if (ev.scl_fall) begin
            cnt_q <= 4'h0;
            if (more_q) begin
              sh_q    <= tx_head;
              sda_oe  <= ~tx_head[7];
              state_q <= S_TX;
            end else begin
              // master declined, wait for stop or start
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data pin only ever pulls low
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // sticky interrupt events, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      irq_st_q <= EV_RESET;
    end else begin
      irq_st_q[EV_RX_BYTE] <= (rx_push & ~rx_full) | (irq_st_q[EV_RX_BYTE]
                              & ~(wr_en & addr == IRQST_OFS & wr_data[EV_RX_BYTE]));
      irq_st_q[EV_TX_REQ]  <= ev_txreq | (irq_st_q[EV_TX_REQ]
                              & ~(wr_en & addr == IRQST_OFS & wr_data[EV_TX_REQ]));
      irq_st_q[EV_RX_OVF]  <= ev_ovf | (irq_st_q[EV_RX_OVF]
                              & ~(wr_en & addr == IRQST_OFS & wr_data[EV_RX_OVF]));
      irq_st_q[EV_TX_UND]  <= ev_under | (irq_st_q[EV_TX_UND]
                              & ~(wr_en & addr == IRQST_OFS & wr_data[EV_TX_UND]));
      irq_st_q[EV_NACK]    <= ev_nack | (irq_st_q[EV_NACK]
                              & ~(wr_en & addr == IRQST_OFS & wr_data[EV_NACK]));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irq_st_q & irq_mask_q)) | gc_flag_q;
    end
  end

  // status word assembled from live flags
  logic [15:0] status_w;
  always_comb begin
    status_w                = 16'h0000;
    status_w[ST_TX_EMPTY]   = ctrl_q[CT_EARLY_TX] ? early_q : tx_empty;
    status_w[ST_TX_UNDER]   = under_q;
    status_w[ST_TX_REQ]     = txreq_q;
    status_w[ST_RX_REQ]     = (rx_cnt_q != 2'h0);
    status_w[ST_RX_OVF]     = ovf_q;
    status_w[ST_NACK]       = nack_q;
    status_w[ST_BUSY]       = busy_q;
    status_w[ST_GC]         = gc_flag_q;
    status_w[ST_GCID_LO+:2] = gcid_q;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      unique case (addr)
        CTRL_OFS:   rd_data <= {10'h000, ctrl_q};
        STATUS_OFS: rd_data <= status_w;
        RXDATA_OFS: rd_data <= {8'h00, (rx_cnt_q != 2'h0) ? rx_mem[rx_rp_q] : 8'h00};
        ALT_OFS:    rd_data <= {8'h00, alt_q};
        ID0_OFS:    rd_data <= {8'h00, id_q};
        IRQST_OFS:  rd_data <= {11'h000, irq_st_q};
        IRQMSK_OFS: rd_data <= {11'h000, irq_mask_q};
        default:    rd_data <= 16'h0000;
      endcase
    end else begin
      rd_data <= 16'h0000;
    end
  end
endmodule

/* tb/i2c_slave_status_flags_checker.sv */
`timescale 1ns/1ps
module i2c_slave_status_flags_checker
  import i2c_slv_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic              scl_in,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              sda_oe,
  input wire logic              irq
);
  logic st_q; // status read last cycle
  logic gc_q; // gc flag seen, no write since
  logic on_q; // copy of software enable
  logic ct_q; // control read last cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // shadow state; a call reset is only learnt at the next control read
  always_ff @(posedge clk) begin
    st_q <= rd_en && addr == STATUS_OFS;
    ct_q <= rd_en && addr == CTRL_OFS;
    if (reset || wr_en) gc_q <= 1'b0;
    else if (st_q && rd_data[ST_GC]) gc_q <= 1'b1;
    if (reset) on_q <= 1'b0;
    else if (wr_en && addr == CTRL_OFS) on_q <= wr_data[CT_SLAVE_ON];
    else if (ct_q) on_q <= rd_data[CT_SLAVE_ON];
  end
  property p_gc_irq;
    st_q && rd_data[ST_GC] |-> irq;
  endproperty
  a_gc_irq: assert property (p_gc_irq) else $error("gc flag without irq");
  property p_gc_hold;
    st_q && gc_q |-> rd_data[ST_GC];
  endproperty
  a_gc_hold: assert property (p_gc_hold) else $error("gc flag lost");
  property p_irq_fall;
    $fell(irq) |-> $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
  property p_rx_hi;
    $past(rd_en) && $past(addr) == RXDATA_OFS |-> rd_data[15:8] == 8'h00;
  endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("rx upper byte set");
  property p_idle_rd;
    !$past(rd_en) |-> rd_data == 16'h0000;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data stands");
  property p_rd_clr;
    st_q && $past(st_q, 2) |-> rd_data[ST_NACK] == 1'b0 && rd_data[ST_RX_OVF] == 1'b0
      && rd_data[ST_TX_UNDER] == 1'b0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("flag kept on read");
  property p_off;
    !on_q |=> !sda_oe;
  endproperty
  a_off: assert property (p_off) else $error("drive while disabled");
  property p_ack_rise;
    $rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2);
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("drive outside scl low");
endmodule

bind i2c_slave_status_flags i2c_slave_status_flags_checker chk (
  .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .scl_in(scl_in), .rd_data(rd_data), .sda_oe(sda_oe), .irq(irq)
);

/* tb/i2c_master_model.sv */
`timescale 1ns/1ps
// bus master; scl stands high between frames, 800 ns bit slots
module i2c_master_model (
  output logic      scl,      // link clock
  output logic      hold_low, // 1 pulls sda low
  input  wire logic sda       // resolved line
);
  initial begin
    scl = 1'b1;
    hold_low = 1'b0;
  end
  // one bit: data set mid-low, sampled mid-high
  task automatic slot(input logic b, output logic r);
    hold_low = ~b;
    #200 scl = 1'b1;
    #200 r = sda;
    #200 scl = 1'b0;
    #200;
  endtask
  // sda falls while scl high
  task automatic start();
    hold_low = 1'b0;
    #237 scl = 1'b1;
    #200 hold_low = 1'b1;
    #400 scl = 1'b0;
    #200;
  endtask
  // sda rises while scl high
  task automatic stop();
    hold_low = 1'b1;
    #200 scl = 1'b1;
    #400 hold_low = 1'b0;
    #400;
  endtask
  // msb first, then ack slot
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask
  // last high ends the read
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(last, r);
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
  import i2c_slv_pkg::*;
;
  logic              clk;        // system clock
  logic              reset;      // sync reset
  logic [ADDR_W-1:0] addr;       // register address
  logic [DATA_W-1:0] wr_data;    // write data
  logic              wr_en;      // write strobe
  logic              rd_en;      // read strobe
  logic [DATA_W-1:0] rd_data;    // read data
  logic              sda_oe;     // slave pulls sda
  logic              sda_pin;    // data pin value
  logic              irq;        // interrupt
  logic              scl;        // master clock
  logic              hold_low;   // master pulls sda
  wire               sda = ~(hold_low | sda_oe); // pull-up
  int                n_mismatch; // failed compares
  int                checks;     // compares made
  logic              ack;        // slave ack seen
  logic [7:0]        rx;         // byte read back
  i2c_slave_status_flags dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .scl_in(scl), .sda_in(sda), .rd_data(rd_data),
    .sda_out(sda_pin), .sda_oe(sda_oe), .irq(irq));
  i2c_master_model m (.scl(scl), .hold_low(hold_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // data only stands in the cycle after the strobe
  task automatic rchk(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp);
  endtask
  // clear all events, irq must drop
  task automatic clr_irq();
    wr(IRQST_OFS, 16'h001f);
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
  endtask
  task automatic t_reset();
    rchk(STATUS_OFS, 16'h0001);
    rchk(RXDATA_OFS, 16'h0000);
    rchk(32'h4000_3500, 16'h0000);
    chk({15'h0, sda_pin}, 16'h0000);
    wr(ID0_OFS, 16'h0054);
    wr(IRQMSK_OFS, 16'h001f);
    wr(CTRL_OFS, 16'h0001);
    $display("reset test done");
  endtask
  // three bytes into a two-deep queue
  task automatic t_rx();
    m.start();
    m.wb(8'h54, ack);
    rchk(STATUS_OFS, 16'h0041);
    m.wb(8'ha5, ack);
    m.wb(8'h3c, ack);
    chk({15'h0, ack}, 16'h0001);
    m.wb(8'h77, ack);
    m.stop();
    chk({15'h0, irq}, 16'h0001);
    rchk(STATUS_OFS, 16'h0019);
    rchk(STATUS_OFS, 16'h0009);
    rchk(RXDATA_OFS, 16'h00a5);
    rchk(RXDATA_OFS, 16'h003c);
    rchk(STATUS_OFS, 16'h0001);
    rchk(IRQST_OFS, 16'h0005);
    clr_irq();
    $display("receive test done");
  endtask
  // refusals, then a repeated start that matches nobody
  task automatic t_nack();
    m.start();
    m.wb(8'h55, ack);
    chk({15'h0, ack}, 16'h0000);
    m.stop();
    rchk(STATUS_OFS, 16'h0021);
    rchk(STATUS_OFS, 16'h0001);
    wr(CTRL_OFS, 16'h0021);
    m.start();
    m.wb(8'h54, ack);
    chk({15'h0, ack}, 16'h0000);
    m.stop();
    rchk(STATUS_OFS, 16'h0021);
    wr(CTRL_OFS, 16'h0001);
    m.start();
    m.wb(8'h54, ack);
    m.start();
    m.wb(8'h20, ack);
    rchk(STATUS_OFS, 16'h0001);
    m.stop();
    clr_irq();
    $display("nack test done");
  endtask
  // one byte queued, master asks for two
  task automatic t_tx();
    wr(TXDATA_OFS, 16'h0096);
    rchk(STATUS_OFS, 16'h0000);
    m.start();
    m.wb(8'h55, ack);
    chk({15'h0, ack}, 16'h0001);
    m.rb(1'b0, rx);
    chk({8'h00, rx}, 16'h0096);
    m.rb(1'b1, rx);
    chk({8'h00, rx}, 16'h00ff);
    m.stop();
    rchk(STATUS_OFS, 16'h0007);
    rchk(STATUS_OFS, 16'h0001);
    clr_irq();
    $display("transmit test done");
  endtask
  // early flag is read-clear, not the empty level
  task automatic t_early();
    wr(CTRL_OFS, 16'h0011);
    wr(TXDATA_OFS, 16'h005a);
    m.start();
    m.wb(8'h55, ack);
    m.rb(1'b1, rx);
    chk({8'h00, rx}, 16'h005a);
    m.stop();
    rchk(STATUS_OFS, 16'h0005);
    rchk(STATUS_OFS, 16'h0000);
    clr_irq();
    $display("early test done");
  endtask
  // hardware call keeps its second byte queued
  task automatic t_gc_hw();
    wr(ALT_OFS, 16'h0055);
    wr(CTRL_OFS, 16'h0007);
    m.start();
    m.wb(8'h00, ack);
    m.wb(8'h55, ack);
    m.stop();
    rchk(STATUS_OFS, 16'h0389);
    rchk(RXDATA_OFS, 16'h0055);
    wr(CTRL_OFS, 16'h0008);
    rchk(STATUS_OFS, 16'h0001);
    wr(CTRL_OFS, 16'h0003);
    m.start();
    m.wb(8'h00, ack);
    m.wb(8'h04, ack);
    m.stop();
    rchk(STATUS_OFS, 16'h0289);
    rchk(RXDATA_OFS, 16'h0004);
    wr(CTRL_OFS, 16'h0008);
    clr_irq();
    $display("hardware call test done");
  endtask
  // reset call restores defaults but keeps its own flag
  task automatic t_gc_rst();
    wr(CTRL_OFS, 16'h0003);
    m.start();
    m.wb(8'h00, ack);
    m.wb(8'h06, ack);
    m.stop();
    rchk(STATUS_OFS, 16'h0181);
    rchk(CTRL_OFS, 16'h0000);
    rchk(ID0_OFS, 16'h0000);
    rchk(STATUS_OFS, 16'h0181);
    wr(ID0_OFS, 16'h0054);
    m.start();
    m.wb(8'h54, ack);
    chk({15'h0, ack}, 16'h0000);
    m.stop();
    chk({15'h0, irq}, 16'h0001);
    wr(CTRL_OFS, 16'h0008);
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    $display("reset call test done");
  endtask
  initial begin
    reset = 1'b1;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_rx();
    t_nack();
    t_tx();
    t_early();
    t_gc_hw();
    t_gc_rst();
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
